// ==== src/adc_scan_sequencer.v ====
// Functional notes
// RULE1: Results are 16-bit two's complement words
// RULE2: Bipolar codes pass converter's two's complement
// RULE3: Unipolar codes offset by flipping the MSB
// RULE4: Convert command starts exactly one conversion; the code ignores the command while scan_run is set
// RULE5: Status shows data available for polling
// RULE6: Entry holds channel, gain, polarity, configuration
// RULE7: Conversions follow queue order, entry settings
// RULE8: Queue retained, wraps to first entry
// RULE9: Queue holds up to 512 entries
// RULE10: 24-bit scan interval count on timebase
// RULE11: 16-bit sample interval count on timebase
// RULE12: 24-bit post scan count after trigger
// RULE13: 9-bit samples per scan count
// RULE14: Scan starts from counters; timebase selectable
// RULE15: External timebase continuous, 1 to 40MHz
// RULE16: Software keeps sample interval above minimum
// RULE17: Scan interval covers samples times sample interval
// RULE18: Hold strobe output for external hold circuits
// RULE19: Software loads entries equal to samples count
// RULE20: Each result pushed to data FIFO output; the code drops the result and sets overrun while FIFO_FULL is high
// RULE21: Acquire post scan count scans, then stop
// RULE22: Samples one interval apart, scans one interval apart
// RULE23: Queue pointer continues across scans, wraps
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_consts.vh"
module adc_scan_sequencer (
  // Clock and reset
  input  wire        SYS_CLK,
  input  wire        NRST,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [11:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  // Timebases
  input  wire        INT_TIMEBASE_TICK,
  input  wire        EXT_TIMEBASE_IN,
  // Converter front end
  output reg  [5:0]  MUX_CHANNEL,
  output reg  [1:0]  GAIN_SELECT,
  output reg         UNIPOLAR,
  output reg  [1:0]  INPUT_CONFIG,
  output reg         CONVERT_START,
  input  wire        CONVERT_BUSY,
  input  wire [15:0] CONVERT_DATA,
  output reg         SIMULTANEOUS_HOLD_OUT,
  // Data FIFO push side
  output reg         FIFO_PUSH,
  output reg  [15:0] FIFO_DATA,
  input  wire        FIFO_FULL,
  // Acquisition state
  output reg         SCAN_ACTIVE
);
  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_BUSY = 2'h2;
  localparam ST_DONE = 2'h3;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg                  ext_tb_sel;
  reg [23:0]           scan_interval_count;
  reg [15:0]           sample_interval_count;
  reg [23:0]           post_scan_count;
  reg [8:0]            samples_per_scan_count;
  reg [9:0]            queue_len;
  reg [8:0]            queue_addr;
  reg [`QE_WIDTH-1:0]  queue [0:`QUEUE_DEPTH-1];
  reg [15:0]           result;
  reg                  data_ready;
  reg                  overrun;
  reg [8:0]            qptr;
  reg [23:0]           scans_done;
  reg [8:0]            samples_done;
  reg                  scan_run;
  reg                  in_scan;
  reg                  sample_pending;
  reg                  sw_pending;
  reg [1:0]            state;
  reg [3:0]            hold_cnt;
  reg                  from_scan;
  reg                  ext_s1;
  reg                  ext_s2;
  reg                  ext_s3;
  reg                  busy_s1;
  reg                  busy_s2;
  reg [15:0]           data_s1;
  reg [15:0]           data_s2;
  reg                  ph_valid;
  reg                  ph_write;
  reg [11:0]           ph_addr;
  reg [31:0]           next_rdata;
  reg [`QE_WIDTH-1:0]  entry;

  wire tb_tick;
  wire scan_fire;
  wire sample_fire;
  wire wr_en;
  wire rd_en;
  wire last_scan;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [8:0] next_ptr;
    input [8:0] p;
    input [9:0] len;
    begin
      if ({1'b0, p} + 10'h001 >= len)
        next_ptr = 9'h000;
      else
        next_ptr = p + 9'h001;
    end
  endfunction

  // Unipolar mid-range is zero code; bipolar taken as is
  function [15:0] code_of;
    input [15:0] raw;
    input        uni;
    begin
      code_of = uni ? (raw ^ `UNIPOLAR_FLIP) : raw;
    end
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // Data bus sampled twice, read only after busy falls
  always @(posedge SYS_CLK)
  begin
    ext_s1  <= EXT_TIMEBASE_IN;
    ext_s2  <= ext_s1;
    ext_s3  <= ext_s2;
    busy_s1 <= CONVERT_BUSY;
    busy_s2 <= busy_s1;
    data_s1 <= CONVERT_DATA;
    data_s2 <= data_s1;
  end

  // Internal source or external edge; external capped by clock rate
  assign tb_tick = ext_tb_sel ? (ext_s2 & ~ext_s3) : INT_TIMEBASE_TICK; // [RULE14]

  // ----------------------------------------
  // Interval counters
  // ----------------------------------------
  adc_timebase_counter #(.WIDTH(24)) u_scan_ctr (
    .clk    (SYS_CLK),
    .nrst   (NRST),
    .run    (scan_run),
    .tick   (tb_tick),
    .period (scan_interval_count),
    .fire   (scan_fire)
  ); // [RULE10]

  adc_timebase_counter #(.WIDTH(16)) u_sample_ctr (
    .clk    (SYS_CLK),
    .nrst   (NRST),
    .run    (in_scan),
    .tick   (tb_tick),
    .period (sample_interval_count),
    .fire   (sample_fire)
  ); // [RULE11]

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign wr_en     = ph_valid & ph_write;
  assign rd_en     = HSEL & HREADY & HTRANS[1] & ~HWRITE;
  assign last_scan = (scans_done + 24'h000001 >= post_scan_count);

  always @*
  begin
    entry = queue[queue_addr];
    case (HADDR)
      `REG_CONTROL:    next_rdata = {30'h0, ext_tb_sel, scan_run};
      `REG_STATUS:     next_rdata = {28'h0, overrun, (state != ST_IDLE), SCAN_ACTIVE,
                                     data_ready}; // [RULE5]
      `REG_SCAN_IVL:   next_rdata = {8'h00, scan_interval_count};
      `REG_SAMPLE_IVL: next_rdata = {16'h0000, sample_interval_count};
      `REG_POST_SCAN:  next_rdata = {8'h00, post_scan_count};
      `REG_SAMPLES:    next_rdata = {23'h0, samples_per_scan_count};
      `REG_QUEUE_LEN:  next_rdata = {22'h0, queue_len};
      `REG_QUEUE_ADDR: next_rdata = {23'h0, queue_addr};
      `REG_QUEUE_DATA: next_rdata = {21'h0, entry};
      `REG_RESULT:     next_rdata = {16'h0000, result}; // [RULE1]
      default:         next_rdata = 32'h00000000;
    endcase
  end

  // Zero wait states; unmapped reads zero, writes dropped
  always @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      ph_valid  <= 1'b0;
      ph_write  <= 1'b0;
      ph_addr   <= 12'h000;
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      ph_valid <= HSEL & HREADY & HTRANS[1];
      ph_write <= HWRITE;
      ph_addr  <= HADDR;
      if (rd_en)
        HRDATA <= next_rdata;
    end
  end

  // Queue storage kept across scans and resets of acquisition
  always @(posedge SYS_CLK)
  begin
    if (wr_en && ph_addr == `REG_QUEUE_DATA)
      queue[queue_addr] <= HWDATA[`QE_WIDTH-1:0]; // [RULE6] [RULE9] [RULE8]
  end

  // ----------------------------------------
  // Configuration and sequencing
  // ----------------------------------------
  always @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      ext_tb_sel             <= 1'b0;
      scan_interval_count    <= 24'h000000;
      sample_interval_count  <= 16'h0000;
      post_scan_count        <= 24'h000000;
      samples_per_scan_count <= 9'h000;
      queue_len              <= 10'h000;
      queue_addr             <= 9'h000;
      result                 <= 16'h0000;
      data_ready             <= 1'b0;
      overrun                <= 1'b0;
      qptr                   <= 9'h000;
      scans_done             <= 24'h000000;
      samples_done           <= 9'h000;
      scan_run               <= 1'b0;
      in_scan                <= 1'b0;
      sample_pending         <= 1'b0;
      sw_pending             <= 1'b0;
      state                  <= ST_IDLE;
      hold_cnt               <= 4'h0;
      from_scan              <= 1'b0;
      MUX_CHANNEL            <= 6'h00;
      GAIN_SELECT            <= 2'h0;
      UNIPOLAR               <= 1'b0;
      INPUT_CONFIG           <= `CFG_REF_SE;
      CONVERT_START          <= 1'b0;
      SIMULTANEOUS_HOLD_OUT  <= 1'b0;
      FIFO_PUSH              <= 1'b0;
      FIFO_DATA              <= 16'h0000;
      SCAN_ACTIVE            <= 1'b0;
    end
    else
    begin
      CONVERT_START <= 1'b0;
      FIFO_PUSH     <= 1'b0;
      SCAN_ACTIVE   <= scan_run;
      if (rd_en && HADDR == `REG_RESULT && !(state == ST_BUSY && !busy_s2))
        data_ready <= 1'b0;
      if (wr_en)
      begin
        case (ph_addr)
          `REG_CONTROL:
          begin
            ext_tb_sel <= HWDATA[`CTL_EXT_TB];
            if (HWDATA[`CTL_SCAN_START] && !scan_run)
            begin
              scan_run     <= 1'b1;
              scans_done   <= 24'h000000;
              in_scan      <= 1'b1;
              samples_done <= 9'h000;
              sample_pending <= 1'b1;
            end
            if (HWDATA[`CTL_SCAN_STOP])
            begin
              scan_run <= 1'b0;
              in_scan  <= 1'b0;
            end
          end
          `REG_SCAN_IVL:   scan_interval_count    <= HWDATA[23:0]; // [RULE10]
          `REG_SAMPLE_IVL: sample_interval_count  <= HWDATA[15:0]; // [RULE11]
          `REG_POST_SCAN:  post_scan_count        <= HWDATA[23:0]; // [RULE12]
          `REG_SAMPLES:    samples_per_scan_count <= HWDATA[8:0]; // [RULE13]
          `REG_QUEUE_LEN:
          begin
            queue_len <= (HWDATA[10:0] > 11'h200) ? 10'h200 : HWDATA[9:0]; // [RULE9]
            qptr      <= 9'h000;
          end
          `REG_QUEUE_ADDR: queue_addr <= HWDATA[8:0];
          `REG_QUEUE_DATA: queue_addr <= queue_addr + 9'h001;
          default: ;
        endcase
      end
      // Scan boundaries after the first come only from the scan counter; the first comes from the start write
      if (scan_run && scan_fire && !in_scan)
      begin
        in_scan        <= 1'b1;
        samples_done   <= 9'h000;
        sample_pending <= 1'b1; // [RULE22]
        hold_cnt       <= `HOLD_CYCLES;
        SIMULTANEOUS_HOLD_OUT <= 1'b1; // [RULE18]
      end
      else if (in_scan && sample_fire && samples_done < samples_per_scan_count)
        sample_pending <= 1'b1; // [RULE22]
      if (hold_cnt != 4'h0)
        hold_cnt <= hold_cnt - 4'h1;
      else if (!in_scan)
        SIMULTANEOUS_HOLD_OUT <= 1'b0;
      if (sample_pending && samples_done == 9'h000 && in_scan)
        SIMULTANEOUS_HOLD_OUT <= 1'b1; // [RULE18]
      // Conversion engine; one result per start
      case (state)
        ST_IDLE:
        begin
          if ((sample_pending && in_scan) || sw_pending)
          begin
            from_scan     <= sample_pending && in_scan; // [RULE14]
            if (sample_pending && in_scan)
              sample_pending <= 1'b0;
            else
              sw_pending <= 1'b0;
            MUX_CHANNEL   <= queue[qptr][`QE_CHAN_MSB:`QE_CHAN_LSB]; // [RULE7]
            GAIN_SELECT   <= queue[qptr][`QE_GAIN_MSB:`QE_GAIN_LSB];
            UNIPOLAR      <= queue[qptr][`QE_UNIPOLAR];
            INPUT_CONFIG  <= queue[qptr][`QE_CFG_MSB:`QE_CFG_LSB]; // [RULE6]
            qptr          <= next_ptr(qptr, queue_len); // [RULE8] [RULE23]
            CONVERT_START <= 1'b1;
            state         <= ST_WAIT;
          end
        end
        ST_WAIT:
          if (busy_s2)
            state <= ST_BUSY;
        ST_BUSY:
          if (!busy_s2)
          begin
            result     <= code_of(data_s2, UNIPOLAR); // [RULE1] [RULE2] [RULE3]
            data_ready <= 1'b1; // [RULE5]
            FIFO_DATA  <= code_of(data_s2, UNIPOLAR);
            FIFO_PUSH  <= ~FIFO_FULL; // [RULE20]
            if (FIFO_FULL)
              overrun <= 1'b1;
            state      <= ST_DONE;
          end
        ST_DONE:
        begin
          state <= ST_IDLE;
          if (from_scan)
          begin
            if (samples_done + 9'h001 >= samples_per_scan_count)
            begin
              in_scan    <= 1'b0;
              scans_done <= scans_done + 24'h000001;
              if (last_scan)
                scan_run <= 1'b0; // [RULE21]
            end
            samples_done <= samples_done + 9'h001;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // Command landing as the last one is taken must not be lost
      if (wr_en && ph_addr == `REG_CONVERT && !scan_run)
        sw_pending <= 1'b1; // [RULE4]
    end
  end
endmodule // adc_scan_sequencer
`default_nettype wire

// ==== src/adc_seq_consts.vh ====
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CONTROL      12'h000
`define REG_STATUS       12'h004
`define REG_SCAN_IVL     12'h008
`define REG_SAMPLE_IVL   12'h00C
`define REG_POST_SCAN    12'h010
`define REG_SAMPLES      12'h014
`define REG_QUEUE_LEN    12'h018
`define REG_QUEUE_ADDR   12'h01C
`define REG_QUEUE_DATA   12'h020
`define REG_RESULT       12'h024
`define REG_CONVERT      12'h028
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTL_SCAN_START   0
`define CTL_EXT_TB       1
`define CTL_SCAN_STOP    2
// ----------------------------------------
// Queue entry fields
// ----------------------------------------
`define QE_CHAN_LSB      0
`define QE_CHAN_MSB      5
`define QE_GAIN_LSB      6
`define QE_GAIN_MSB      7
`define QE_UNIPOLAR      8
`define QE_CFG_LSB       9
`define QE_CFG_MSB       10
`define QE_WIDTH         11
`define CFG_REF_SE       2'h0
`define CFG_NONREF_SE    2'h1
`define CFG_DIFFERENTIAL_INPUT         2'h2
// ----------------------------------------
// Sizes and codes
// ----------------------------------------
`define QUEUE_DEPTH      512
`define UNIPOLAR_FLIP    16'h8000
`define HOLD_CYCLES      4'h4
`endif

// ==== src/adc_timebase_counter.v ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Interval counter on timebase ticks
// ----------------------------------------
module adc_timebase_counter #(
  parameter WIDTH = 24
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             run,
  input  wire             tick,
  input  wire [WIDTH-1:0] period,
  output reg              fire
);
  reg [WIDTH-1:0] count;

  // Zero period treated as one tick; fire on reload
  always @(posedge clk)
  begin
    if (!nrst || !run)
    begin
      count <= {WIDTH{1'b0}};
      fire  <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (tick)
      begin
        if (count + 1'b1 >= period)
        begin
          count <= {WIDTH{1'b0}};
          fire  <= 1'b1;
        end
        else
          count <= count + 1'b1;
      end
    end
  end
endmodule // adc_timebase_counter
`default_nettype wire

// ==== sim/adc_front_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Mux, gain stage and converter model
// ----------------------------------------
module adc_front_model (
  // Clock and pace
  input  wire logic        clk,
  input  wire logic        slow,
  // Settings and start
  input  wire logic [5:0]  mux_channel,
  input  wire logic [1:0]  gain_select,
  input  wire logic        unipolar,
  input  wire logic [1:0]  input_config,
  input  wire logic        convert_start,
  // Result
  output var  logic        convert_busy,
  output var  logic [15:0] convert_data
);
  logic [3:0]  left;
  logic [15:0] held;
  initial
  begin
    convert_busy = 1'h0;
    convert_data = 16'h0000;
    left = 4'h0;
  end
  // Word encodes the settings seen at start, so order shows at the output
  always @(posedge clk)
    if (convert_start)
    begin
      held <= {4'hA, mux_channel, gain_select, unipolar, input_config, 1'h1};
      convert_data <= ~convert_data;
      convert_busy <= 1'h1;
      left <= slow ? 4'hC : 4'h3;
    end
    else if (left != 4'h0)
    begin
      left <= left - 4'h1;
      if (left == 4'h1)
      begin
        convert_busy <= 1'h0;
        convert_data <= held;
      end
    end
endmodule // adc_front_model
`default_nettype wire

// ==== sim/adc_seq_checker_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module adc_seq_checker (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  // Bus
  input  wire logic        HSEL,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA,
  input  wire logic        HREADYOUT,
  input  wire logic        HRESP,
  // Converter side
  input  wire logic [5:0]  MUX_CHANNEL,
  input  wire logic [1:0]  GAIN_SELECT,
  input  wire logic        UNIPOLAR,
  input  wire logic [1:0]  INPUT_CONFIG,
  input  wire logic        CONVERT_START,
  input  wire logic        CONVERT_BUSY,
  input  wire logic        SIMULTANEOUS_HOLD_OUT,
  input  wire logic        FIFO_PUSH,
  input  wire logic        SCAN_ACTIVE
);
  logic pending;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // Start issued, result not yet pushed
  always @(posedge SYS_CLK)
    if (!NRST)
      pending <= 1'h0;
    else if (CONVERT_START)
      pending <= 1'h1;
    else if (FIFO_PUSH)
      pending <= 1'h0;
  sequence s_start;
    CONVERT_START;
  endsequence
  sequence s_settled;
    $stable({MUX_CHANNEL, GAIN_SELECT, UNIPOLAR, INPUT_CONFIG})[*2];
  endsequence
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  AST_READ_HOLD: assert property (!$past(HSEL && HREADY && HTRANS[1] && !HWRITE)
    |-> $stable(HRDATA)) else $error("read data moved without a read");
  AST_START_PULSE: assert property (s_start |=> !CONVERT_START)
    else $error("start longer than one cycle");
  AST_START_IDLE: assert property (s_start |-> !CONVERT_BUSY)
    else $error("start while converter busy");
  AST_SETTINGS_HELD: assert property (s_start |=> s_settled)
    else $error("entry settings moved during conversion");
  AST_PUSH_PULSE: assert property (FIFO_PUSH |=> !FIFO_PUSH)
    else $error("push longer than one cycle");
  AST_PUSH_DONE: assert property (FIFO_PUSH |-> !CONVERT_BUSY && pending)
    else $error("push without finished conversion");
  AST_HOLD_MIN: assert property ($rose(SIMULTANEOUS_HOLD_OUT) |-> SIMULTANEOUS_HOLD_OUT[*4])
    else $error("hold strobe too short");
  AST_HOLD_IN_SCAN: assert property ($rose(SIMULTANEOUS_HOLD_OUT) |-> ##[0:2] SCAN_ACTIVE)
    else $error("hold strobe outside a scan");
endmodule // adc_seq_checker
bind adc_scan_sequencer adc_seq_checker adc_seq_checker_inst (.SYS_CLK, .NRST, .HSEL,
  .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MUX_CHANNEL, .GAIN_SELECT,
  .UNIPOLAR, .INPUT_CONFIG, .CONVERT_START, .CONVERT_BUSY, .SIMULTANEOUS_HOLD_OUT,
  .FIFO_PUSH, .SCAN_ACTIVE);
`default_nettype wire

// ==== sim/test_adc_scan_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_consts.vh"
module test_adc_scan_sequencer;
  logic        SYS_CLK, NRST, HSEL, HWRITE, HREADYOUT, HRESP, slow;
  logic        INT_TIMEBASE_TICK, EXT_TIMEBASE_IN, UNIPOLAR, CONVERT_START, CONVERT_BUSY;
  logic        SIMULTANEOUS_HOLD_OUT, FIFO_PUSH, SCAN_ACTIVE, saw_hold;
  logic [11:0] HADDR;
  logic [1:0]  HTRANS, GAIN_SELECT, INPUT_CONFIG;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA, HRDATA;
  logic [5:0]  MUX_CHANNEL;
  logic [15:0] CONVERT_DATA, FIFO_DATA;
  logic [15:0] pushed[$];
  int          t_start[$];
  int          n_mismatch, checks, n_start, cyc;
  // Entries: ch3 bipolar ref, ch1 differential_input, ch2 unipolar nonref, ch1 differential_input
  logic [10:0] entry[4] = '{11'h003, 11'h481, 11'h342, 11'h481};
  adc_scan_sequencer adc_scan_sequencer_inst (.SYS_CLK, .NRST, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .INT_TIMEBASE_TICK, .EXT_TIMEBASE_IN, .MUX_CHANNEL, .GAIN_SELECT, .UNIPOLAR,
    .INPUT_CONFIG, .CONVERT_START, .CONVERT_BUSY, .CONVERT_DATA, .SIMULTANEOUS_HOLD_OUT,
    .FIFO_PUSH, .FIFO_DATA, .FIFO_FULL(1'h0), .SCAN_ACTIVE);
  adc_front_model adc_front_model_inst (.clk(SYS_CLK), .slow, .mux_channel(MUX_CHANNEL),
    .gain_select(GAIN_SELECT), .unipolar(UNIPOLAR), .input_config(INPUT_CONFIG),
    .convert_start(CONVERT_START), .convert_busy(CONVERT_BUSY), .convert_data(CONVERT_DATA));
  initial
  begin
    SYS_CLK = 1'h0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  // Tick every other cycle; external pin at 2.5 MHz, within its range
  always @(posedge SYS_CLK)
  begin
    INT_TIMEBASE_TICK <= ~INT_TIMEBASE_TICK;
    EXT_TIMEBASE_IN <= cyc[2];
    cyc <= cyc + 1;
    if (CONVERT_START === 1'h1)
    begin
      n_start++;
      t_start.push_back(cyc);
    end
    if (FIFO_PUSH === 1'h1)
      pushed.push_back(FIFO_DATA);
    if (SIMULTANEOUS_HOLD_OUT === 1'h1)
      saw_hold <= 1'h1;
  end
  function automatic logic [15:0] expect_word(input logic [10:0] e);
    logic [15:0] raw;
    raw = {4'hA, e[5:0], e[7:6], e[8], e[10:9], 1'h1};
    expect_word = e[8] ? raw ^ `UNIPOLAR_FLIP : raw;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  // One single transfer; entered and left just after a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
    r = HRDATA;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] x);
    bus(1'h0, a, 32'h0, x);
  endtask
  task automatic test_regs;
    logic [31:0] x;
    check({HREADYOUT, SCAN_ACTIVE, SIMULTANEOUS_HOLD_OUT}, 32'h4);
    wr(`REG_CONTROL, 32'h2);
    rd(`REG_CONTROL, x);
    check(x & 32'h3, 32'h2);
    wr(`REG_CONTROL, 32'h0);
    rd(12'h100, x);
    check(x, 32'h0);
  endtask
  task automatic test_poll;
    logic [31:0] x;
    int          s;
    wr(`REG_QUEUE_ADDR, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(`REG_QUEUE_DATA, {21'h0, entry[i]});
    wr(`REG_QUEUE_LEN, 32'h4);
    // Ten reads run past the queue end and wrap to the first entry
    for (int i = 0; i < 10; i++)
    begin
      slow = i[0];
      s = n_start;
      wr(`REG_CONVERT, 32'h1);
      for (int k = 0; k < 60 && x[0] !== 1'h1; k++)
        rd(`REG_STATUS, x);
      check(x[0], 32'h1);
      rd(`REG_RESULT, x);
      check(x[15:0], expect_word(entry[i % 4]));
      check(n_start - s, 1);
      rd(`REG_STATUS, x);
      check(x[0], 32'h0);
    end
  endtask
  task automatic test_scan;
    slow = 1'h0;
    wr(`REG_SAMPLE_IVL, 32'hE);
    wr(`REG_SCAN_IVL, 32'h20);
    wr(`REG_POST_SCAN, 32'h2);
    wr(`REG_SAMPLES, 32'h2);
    wr(`REG_QUEUE_LEN, 32'h4);
    pushed.delete();
    t_start.delete();
    wr(`REG_CONTROL, 32'h1);
    for (int k = 0; k < 2000 && (k < 10 || SCAN_ACTIVE !== 1'h0); k++)
      @(posedge SYS_CLK);
    repeat (40) @(posedge SYS_CLK);
    check({saw_hold, SCAN_ACTIVE}, 32'h2);
    check(pushed.size(), 4);
    check(t_start.size(), 4);
    // Second scan resumes at entry 2, so four samples cover the whole queue
    for (int i = 0; i < 4; i++)
      check(pushed[i], expect_word(entry[i]));
    check(t_start[1] - t_start[0] inside {[26:30]}, 1);
    check(t_start[3] - t_start[2] inside {[26:30]}, 1);
    check(t_start[2] - t_start[0] inside {[62:66]}, 1);
  endtask
  // External pin ticks every 8 cycles; one scan of two samples
  task automatic test_ext;
    wr(`REG_SAMPLE_IVL, 32'h4);
    wr(`REG_SCAN_IVL, 32'h8);
    wr(`REG_POST_SCAN, 32'h1);
    wr(`REG_SAMPLES, 32'h2);
    wr(`REG_QUEUE_LEN, 32'h2);
    pushed.delete();
    t_start.delete();
    wr(`REG_CONTROL, 32'h3);
    for (int k = 0; k < 2000 && (k < 10 || SCAN_ACTIVE !== 1'h0); k++)
      @(posedge SYS_CLK);
    repeat (40) @(posedge SYS_CLK);
    check(pushed.size(), 2);
    check(t_start.size(), 2);
    check(pushed[0], expect_word(entry[0]));
    check(pushed[1], expect_word(entry[1]));
    check(t_start[1] - t_start[0] inside {[24:34]}, 1);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    {NRST, HSEL, HWRITE, HADDR, HTRANS, HWDATA, slow, saw_hold} = '0;
    {INT_TIMEBASE_TICK, EXT_TIMEBASE_IN} = 2'h0;
    HSIZE = 3'h2;
    {n_mismatch, checks, n_start, cyc} = '0;
    repeat (12) @(posedge SYS_CLK);
    NRST <= 1'h1;
    @(posedge SYS_CLK);
    test_regs();
    test_poll();
    test_scan();
    test_ext();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    n_mismatch++;
    test_done();
  end
endmodule // test_adc_scan_sequencer
`default_nettype wire
